/* src/cco_regs.svh */
// register offsets, field positions, reset values and timing counts
// Function
// - two outputs, four functions, window on A
// - software output follows force when enabled
// - software flag sticky, set on disabled force
// - isochronous software output moves at output instant
// - comparator drives output, flag held while true
// - comparator switches without waiting for bus
// - pulse on hit, flag held while timing
// - pulse on hit fires only in main direction
// - forced pulse output ends after duration
// - duration 0..510 ms in 2 ms steps
// - zero duration holds while condition holds
// - window compare of count against two thresholds
// - window ignores hysteresis and force
// - window needs zero hysteresis, B software
// - hysteresis 0..255, works across wrap
// - hysteresis freezes result until range left
// - reversal on value under hysteresis resets output
// - exit opposite recorded direction gives pulse
// - force edges set and reset output
// - loads keep counting, range checked
// - run-time changes take effect later
// - function field encodings for A and B
// - status bit positions of flags, levels
`ifndef CCO_REGS_SVH
`define CCO_REGS_SVH
`define CCO_OFS_CTRL 8'h00
`define CCO_OFS_CFG 8'h04
`define CCO_OFS_CMPA 8'h08
`define CCO_OFS_CMPB 8'h0c
`define CCO_OFS_ACK 8'h10
`define CCO_OFS_STAT 8'h14
`define CCO_CTRL_RST 32'h0000_0000
`define CCO_CFG_RST 32'h0000_0000
`define CCO_B_FUNCA 2:0
`define CCO_B_FUNCB 5:4
`define CCO_B_ENA 8
`define CCO_B_ENB 9
`define CCO_B_FRCA 10
`define CCO_B_FRCB 11
`define CCO_B_DIR 13:12
`define CCO_B_ISO 14
`define CCO_B_HYST 7:0
`define CCO_B_DUR 15:8
`define CCO_B_LDERR 1
`define CCO_B_PERR 5
`define CCO_B_STA 11
`define CCO_B_STB 12
`define CCO_B_FLA 19
`define CCO_B_FLB 20
`define CCO_CLK_NS 5
`define CCO_TICK_NS 2000000
`endif

/* src/cco_pkg.sv */
// types shared by the compare output block
package cco_pkg;
	typedef enum logic [2:0] {
		CCO_SW = 3'h0,
		CCO_GE = 3'h1,
		CCO_LE = 3'h2,
		CCO_PULSE = 3'h3,
		CCO_WIN = 3'h4
	} cco_func_t;
	typedef enum logic [1:0] {
		CCO_DIR_NONE = 2'h0,
		CCO_DIR_UP = 2'h1,
		CCO_DIR_DOWN = 2'h2
	} cco_dir_t;
endpackage

/* src/cco_outputs.sv */
// comparison driven control of the two counter outputs
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cco_regs.svh"
module cco_outputs #(
	parameter int TICK_CYCLES = `CCO_TICK_NS / `CCO_CLK_NS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// counter core
	input wire logic [31:0] count,
	input wire logic count_pulse,
	input wire logic count_dir_up,
	input wire logic output_instant,
	// outputs
	output logic output_a,
	output logic output_b
);
	import cco_pkg::*;

	// refuse a divider too short to give a one cycle tick
	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("tick divider too short");
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic [31:0] ctrl, cfg;
	logic [31:0] cmp_v [2];
	logic [7:0] ph_addr;
	logic ph_wr, ph_rd, perr, lderr, last_dir;
	logic [1:0] loaded, out_q, flag;
	logic [31:0] next_hrdata;
	wire take = hsel & hready & htrans[1];
	wire wr_ctrl = ph_wr & (ph_addr == `CCO_OFS_CTRL);
	wire wr_cfg = ph_wr & (ph_addr == `CCO_OFS_CFG);
	wire wr_cmpa = ph_wr & (ph_addr == `CCO_OFS_CMPA);
	wire wr_cmpb = ph_wr & (ph_addr == `CCO_OFS_CMPB);
	wire [1:0] ack = {2{ph_wr & (ph_addr == `CCO_OFS_ACK)}} & hwdata[1:0];
	wire [31:0] stat = ({31'h0, lderr} << `CCO_B_LDERR)
		| ({31'h0, perr} << `CCO_B_PERR)
		| ({30'h0, out_q} << `CCO_B_STA)
		| ({30'h0, flag} << `CCO_B_FLA);
	// read mux, unmapped reads as zero
	always_comb begin
		case (ph_addr)
			`CCO_OFS_CTRL: next_hrdata = ctrl;
			`CCO_OFS_CFG: next_hrdata = cfg;
			`CCO_OFS_CMPA: next_hrdata = cmp_v[0];
			`CCO_OFS_CMPB: next_hrdata = cmp_v[1];
			`CCO_OFS_STAT: next_hrdata = stat;
			default: next_hrdata = 32'h0;
		endcase
	end

	// phase capture; reads take one wait state
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ph_addr <= 8'h0;
			ph_wr <= 1'b0;
			ph_rd <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0;
			hresp <= 1'b0;
		end else begin
			ph_wr <= take & hwrite;
			ph_rd <= take & ~hwrite;
			hreadyout <= ~(take & ~hwrite);
			if (take) begin
				ph_addr <= haddr;
			end
			if (ph_rd) begin
				hrdata <= next_hrdata;
			end
		end
	end

	// ----------------------------------------
	// configuration and compare values
	// ----------------------------------------
	wire [2:0] func_a = ctrl[`CCO_B_FUNCA];
	wire [1:0] func_b = ctrl[`CCO_B_FUNCB];
	wire [1:0] en = {ctrl[`CCO_B_ENB], ctrl[`CCO_B_ENA]};
	wire [1:0] frc = {ctrl[`CCO_B_FRCB], ctrl[`CCO_B_FRCA]};
	wire [1:0] mdir = ctrl[`CCO_B_DIR];
	wire iso = ctrl[`CCO_B_ISO];
	wire [7:0] hyst = cfg[`CCO_B_HYST];
	wire [7:0] dur = cfg[`CCO_B_DUR];
	wire [31:0] ld_val = hwdata;
	// range of a new value against main direction
	wire ld_bad = (mdir == CCO_DIR_UP && ld_val == 32'h7fff_ffff)
		|| (mdir == CCO_DIR_DOWN && $signed(ld_val) < 1);
	// dependency check of the function fields
	wire next_perr = (func_a > CCO_WIN)
		|| (func_a == CCO_WIN && (hyst != 8'h0 || func_b != 2'h0));
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= `CCO_CTRL_RST;
			cfg <= `CCO_CFG_RST;
			cmp_v[0] <= 32'h0;
			cmp_v[1] <= 32'h0;
			loaded <= 2'h0;
			lderr <= 1'b0;
			perr <= 1'b0;
			last_dir <= 1'b1;
		end else begin
			perr <= next_perr;
			if (wr_ctrl) begin
				ctrl <= hwdata;
			end
			if (wr_cfg) begin
				cfg <= hwdata;
			end
			// loads never touch counting
			if (wr_cmpa | wr_cmpb) begin
				lderr <= ld_bad;
			end
			if (wr_cmpa & ~ld_bad) begin
				cmp_v[0] <= ld_val;
				loaded[0] <= 1'b1;
			end
			if (wr_cmpb & ~ld_bad) begin
				cmp_v[1] <= ld_val;
				loaded[1] <= 1'b1;
			end
			if (count_pulse) begin
				last_dir <= count_dir_up;
			end
		end
	end

	// ----------------------------------------
	// 2 ms tick divider
	// ----------------------------------------
	logic [31:0] div;
	logic tick;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div <= 32'h0;
			tick <= 1'b0;
		end else begin
			tick <= (div == 32'(TICK_CYCLES - 1));
			div <= (div == 32'(TICK_CYCLES - 1)) ? 32'h0 : div + 32'h1;
		end
	end

	assign output_a = out_q[0];
	assign output_b = out_q[1];

	// ----------------------------------------
	// per output comparator channels
	// ----------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic hact, hdir, forced, cst, fprev;
		logic [7:0] hr, tmr;
		logic [2:0] mprev;
		wire [2:0] mode = (i == 0) ? func_a : {1'b0, func_b};
		wire [31:0] cv = cmp_v[i];
		wire [31:0] diff = count - cv;
		wire [31:0] adiff = diff[31] ? 32'h0 - diff : diff;
		wire at_val = (diff == 32'h0);
		// range check on the wrapped difference
		wire in_rng = adiff <= {24'h0, hr};
		wire ge = $signed(count) >= $signed(cv);
		wire le = $signed(count) <= $signed(cv);
		wire dir_ok = (mdir == CCO_DIR_NONE)
			|| (mdir == CCO_DIR_UP && count_dir_up)
			|| (mdir == CCO_DIR_DOWN && !count_dir_up);
		wire thr_lo = $signed(cmp_v[1]) <= $signed(cmp_v[0]);
		wire in_win = $signed(count) >= $signed(cmp_v[1])
			&& $signed(count) <= $signed(cmp_v[0]);
		wire outside = $signed(count) < $signed(cmp_v[0])
			|| $signed(count) > $signed(cmp_v[1]);
		wire win = (i == 0) && (thr_lo ? in_win : outside);
		wire is_sw = (mode == CCO_SW);
		wire is_lvl = (mode == CCO_GE) || (mode == CCO_LE);
		wire is_pls = (mode == CCO_PULSE);
		wire is_win = (mode == CCO_WIN) && !perr;
		wire cond = (mode == CCO_GE) ? ge : le;
		wire hit = count_pulse && at_val && dir_ok;
		wire leave = count_pulse && hact && !in_rng;
		wire rev = count_pulse && hact && at_val
			&& (count_dir_up != last_dir);
		wire f_up = frc[i] & ~fprev;
		wire f_dn = ~frc[i] & fprev;
		wire sw_go = !iso || output_instant;
		wire hold = cst || tmr != 8'h0;
		wire win_on = en[i] && win && (&loaded);

		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				out_q[i] <= 1'b0;
				flag[i] <= 1'b0;
				hact <= 1'b0;
				hdir <= 1'b0;
				forced <= 1'b0;
				cst <= 1'b0;
				fprev <= 1'b0;
				hr <= 8'h0;
				tmr <= 8'h0;
				mprev <= 3'h0;
			end else begin
				fprev <= frc[i];
				mprev <= mode;
				// sticky flag, set wins over acknowledge
				if (ack[i] && !hold) begin
					flag[i] <= 1'b0;
				end
				if (cst || tmr != 8'h0 || (is_sw && out_q[i])
						|| (is_sw && f_up && !en[i])) begin
					flag[i] <= 1'b1;
				end
				if (is_sw) begin
					hact <= 1'b0;
					forced <= 1'b0;
					tmr <= 8'h0;
					cst <= 1'b0;
					if (sw_go) begin
						out_q[i] <= frc[i] & en[i];
					end
				end else if (is_win) begin
					// no hysteresis, force ignored
					hact <= 1'b0;
					cst <= win;
					out_q[i] <= win_on;
				end else begin
					if (mode != mprev && !hact) begin
						out_q[i] <= 1'b0;
					end
					if (leave) begin
						hact <= 1'b0;
						if (is_lvl) begin
							cst <= cond;
							out_q[i] <= (cond & en[i]) | forced;
						end else if (is_pls && dur == 8'h0) begin
							cst <= 1'b0;
							out_q[i] <= forced;
						end else if (is_pls && count_dir_up != hdir
								&& en[i]) begin
							tmr <= dur;
							out_q[i] <= 1'b1;
						end
					end else if (rev && is_lvl) begin
						out_q[i] <= 1'b0;
					end else if (!hact && count_pulse) begin
						if (is_lvl) begin
							cst <= cond;
							hact <= cond && hyst != 8'h0;
							hr <= hyst;
							out_q[i] <= (cond & en[i]) | forced;
						end else if (is_pls && hit) begin
							cst <= (dur == 8'h0);
							hact <= hyst != 8'h0;
							hdir <= count_dir_up;
							hr <= hyst;
							if (en[i]) begin
								out_q[i] <= 1'b1;
								tmr <= dur;
							end
						end else if (is_pls && dur == 8'h0) begin
							cst <= 1'b0;
							out_q[i] <= forced;
						end
					end
					// timed pulse expiry
					if (tick && tmr != 8'h0) begin
						tmr <= tmr - 8'h1;
						if (tmr == 8'h1) begin
							out_q[i] <= 1'b0;
							forced <= 1'b0;
						end
					end
					// force edges override the comparator
					if (f_up) begin
						forced <= !is_pls || dur == 8'h0;
						out_q[i] <= 1'b1;
						if (is_pls) begin
							tmr <= dur;
						end
					end else if (f_dn) begin
						forced <= 1'b0;
						out_q[i] <= 1'b0;
						tmr <= 8'h0;
					end
				end
			end
		end

		// ------------------------------------
		// checks
		// ------------------------------------
		sw_follow_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			is_sw && !iso ##1 is_sw |-> out_q[i] == $past(frc[i] & en[i]))
			else $error("software output wrong");
		iso_hold_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			is_sw && iso && !output_instant ##1 is_sw |-> $stable(out_q[i]))
			else $error("output moved off instant");
		sw_flag_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			is_sw && out_q[i] |=> flag[i])
			else $error("flag not set by output");
		pulse_flag_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			tmr != 8'h0 |=> flag[i])
			else $error("flag cleared during pulse");
		pulse_end_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			is_pls && tick && tmr == 8'h1 && !f_up ##1 is_pls |-> !out_q[i])
			else $error("pulse did not end");
		lvl_on_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			is_lvl && count_pulse && !hact && cond && en[i] && !f_dn
			|=> out_q[i])
			else $error("comparator did not switch");
		ack_hold_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			flag[i] && cst |=> flag[i])
			else $error("flag cleared while true");
		win_out_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			is_win ##1 is_win |-> out_q[i] == $past(win_on))
			else $error("window output wrong");
		// hysteresis, reversal, zero duration and force corners
		rev_reset_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			is_lvl && rev && !f_up |=> !out_q[i])
			else $error("reversal did not reset output");
		zero_dur_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			is_pls && dur == 8'h0 && count_pulse && !hact && !hit
			&& !forced && !f_up |=> !out_q[i])
			else $error("zero duration output held");
		force_dn_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			!is_sw && !is_win && f_dn |=> !out_q[i])
			else $error("falling force did not reset");
		hyst_hold_a: assert property (
			@(posedge ref_clk) disable iff (!nrst)
			is_lvl && hact && count_pulse && in_rng && !at_val && !f_up
			&& !f_dn && tmr == 8'h0 |=> $stable(out_q[i]))
			else $error("output moved under hysteresis");
		// main scenarios reached
		cv_pulse_c: cover property (@(posedge ref_clk) disable iff (!nrst)
			is_pls && hit && en[i] ##1 tmr != 8'h0);
		cv_hyst_c: cover property (@(posedge ref_clk) disable iff (!nrst)
			hact ##1 leave);
		cv_win_c: cover property (@(posedge ref_clk) disable iff (!nrst)
			is_win && out_q[i]);
		cv_rev_c: cover property (@(posedge ref_clk) disable iff (!nrst)
			is_lvl && rev);
		cv_force_c: cover property (@(posedge ref_clk) disable iff (!nrst)
			!is_sw && f_up);
	end

	perr_dep_a: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		func_a == CCO_WIN && hyst != 8'h0 |=> perr)
		else $error("window dependency not flagged");
endmodule

/* tb/cco_counter_model.sv */
// counter core and bus cycle model feeding the compare block
`timescale 1ns/1ps
module cco_counter_model (
	// clock
	input wire logic ref_clk,
	// counter core side
	output logic [31:0] count,
	output logic count_pulse,
	output logic count_dir_up,
	output logic output_instant
);
	// idle levels, counter parked at zero
	initial begin
		count = 32'h0000_0000;
		count_pulse = 1'b0;
		count_dir_up = 1'b1;
		output_instant = 1'b0;
	end
	// one step, new value shown with the pulse
	task automatic step(input logic up);
		@(posedge ref_clk);
		count <= up ? count + 32'h1 : count - 32'h1;
		count_dir_up <= up;
		count_pulse <= 1'b1;
		@(posedge ref_clk);
		count_pulse <= 1'b0;
	endtask
	// one-cycle output instant of the bus cycle
	task automatic instant();
		@(posedge ref_clk);
		output_instant <= 1'b1;
		@(posedge ref_clk);
		output_instant <= 1'b0;
	endtask
endmodule

/* tb/cco_outputs_tb.sv */
// self-checking bench for the compare output block
`timescale 1ns/1ps
`include "cco_regs.svh"
module cco_outputs_tb;
	import cco_pkg::*;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic [31:0] count;
	logic [31:0] v;
	logic hreadyout;
	logic hresp;
	logic output_a;
	logic output_b;
	logic count_pulse;
	logic count_dir_up;
	logic output_instant;
	int n_mismatch = 0;
	int n_checks = 0;
	// 200 mhz clock
	always #2.5 ref_clk = ~ref_clk;
	// far side model and block under test
	cco_counter_model u_cnt (
		.ref_clk(ref_clk),
		.count(count),
		.count_pulse(count_pulse),
		.count_dir_up(count_dir_up),
		.output_instant(output_instant)
	);
	cco_outputs #(.TICK_CYCLES(4)) DUT (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.count(count),
		.count_pulse(count_pulse),
		.count_dir_up(count_dir_up),
		.output_instant(output_instant),
		.output_a(output_a),
		.output_b(output_b)
	);
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// single ahb-lite word transfer, read data lands in v
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		v = hrdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic steps(input int n, input logic up);
		repeat (n) u_cnt.step(up);
		cyc(3);
	endtask
	// reset values and unmapped space
	task automatic t_reset();
		ahb(1'b0, `CCO_OFS_CTRL, 32'h0);
		chk(v, `CCO_CTRL_RST);
		ahb(1'b0, `CCO_OFS_CFG, 32'h0);
		chk(v, `CCO_CFG_RST);
		ahb(1'b0, `CCO_OFS_STAT, 32'h0);
		chk(v, 32'h0);
		chk({29'h0, hresp, output_a, output_b}, 32'h0);
		ahb(1'b1, 8'h40, 32'hffff_ffff);
		ahb(1'b0, 8'h40, 32'h0);
		chk(v, 32'h0);
		$display("test reset done");
	endtask
	// software output, sticky flag, force without enable
	task automatic t_soft();
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0500);
		cyc(3);
		chk(output_a, 1'b1);
		ahb(1'b0, `CCO_OFS_STAT, 32'h0);
		chk(v, 32'h0008_0800);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0100);
		cyc(3);
		chk(output_a, 1'b0);
		ahb(1'b0, `CCO_OFS_STAT, 32'h0);
		chk(v, 32'h0008_0000);
		ahb(1'b1, `CCO_OFS_ACK, 32'h1);
		ahb(1'b0, `CCO_OFS_STAT, 32'h0);
		chk(v, 32'h0);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0400);
		cyc(3);
		chk(output_a, 1'b0);
		ahb(1'b0, `CCO_OFS_STAT, 32'h0);
		chk(v[19], 1'b1);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0);
		ahb(1'b1, `CCO_OFS_ACK, 32'h3);
		$display("test software output done");
	endtask
	// at-or-above on a, at-or-below on b, both at 5
	task automatic t_cmp();
		ahb(1'b1, `CCO_OFS_CMPA, 32'h5);
		ahb(1'b1, `CCO_OFS_CMPB, 32'h5);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0321);
		steps(6, 1'b1);
		chk({output_a, output_b}, 2'b10);
		ahb(1'b1, `CCO_OFS_ACK, 32'h1);
		ahb(1'b0, `CCO_OFS_STAT, 32'h0);
		chk(v[19], 1'b1);
		steps(2, 1'b0);
		chk({output_a, output_b}, 2'b01);
		ahb(1'b1, `CCO_OFS_ACK, 32'h1);
		ahb(1'b0, `CCO_OFS_STAT, 32'h0);
		chk(v[19], 1'b0);
		$display("test comparators done");
	endtask
	// pulse of 3 ticks on hit, then a forced pulse
	task automatic t_pulse();
		ahb(1'b1, `CCO_OFS_CFG, 32'h0300);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0103);
		u_cnt.step(1'b1);
		cyc(2);
		chk(output_a, 1'b1);
		ahb(1'b1, `CCO_OFS_ACK, 32'h1);
		ahb(1'b0, `CCO_OFS_STAT, 32'h0);
		chk(v[19], 1'b1);
		cyc(20);
		chk(output_a, 1'b0);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0503);
		cyc(3);
		chk(output_a, 1'b1);
		cyc(20);
		chk(output_a, 1'b0);
		$display("test pulse done");
	endtask
	// window with threshold_b above threshold_a, then a bad setting
	task automatic t_window();
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0);
		ahb(1'b1, `CCO_OFS_CFG, 32'h0);
		ahb(1'b1, `CCO_OFS_CMPA, 32'ha);
		ahb(1'b1, `CCO_OFS_CMPB, 32'h14);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0104);
		steps(1, 1'b1);
		chk(output_a, 1'b1);
		steps(6, 1'b1);
		chk(output_a, 1'b0);
		ahb(1'b1, `CCO_OFS_CFG, 32'h1);
		ahb(1'b0, `CCO_OFS_STAT, 32'h0);
		chk(v[5], 1'b1);
		ahb(1'b1, `CCO_OFS_CFG, 32'h0);
		$display("test window done");
	endtask
	// isochronous software output waits for the output instant
	task automatic t_iso();
		ahb(1'b1, `CCO_OFS_CTRL, 32'h4500);
		cyc(4);
		chk(output_a, 1'b0);
		u_cnt.instant();
		cyc(2);
		chk(output_a, 1'b1);
		$display("test isochronous done");
	endtask
	// hysteresis freeze, reversal on the value, force edges
	task automatic t_hyst();
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0);
		ahb(1'b1, `CCO_OFS_CMPA, 32'he);
		ahb(1'b1, `CCO_OFS_CFG, 32'h3);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0101);
		steps(2, 1'b1);
		chk(output_a, 1'b1);
		steps(1, 1'b0);
		chk(output_a, 1'b1);
		steps(3, 1'b0);
		chk(output_a, 1'b0);
		steps(5, 1'b1);
		chk(output_a, 1'b1);
		steps(1, 1'b0);
		chk(output_a, 1'b0);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0501);
		cyc(3);
		chk(output_a, 1'b1);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0101);
		cyc(3);
		chk(output_a, 1'b0);
		$display("test hysteresis done");
	endtask
	// pulse only in main direction, then zero duration pulse
	task automatic t_pdir();
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0);
		ahb(1'b1, `CCO_OFS_CFG, 32'h0200);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h2103);
		steps(1, 1'b0);
		steps(1, 1'b1);
		chk(output_a, 1'b0);
		steps(1, 1'b1);
		u_cnt.step(1'b0);
		cyc(2);
		chk(output_a, 1'b1);
		cyc(20);
		chk(output_a, 1'b0);
		ahb(1'b1, `CCO_OFS_CFG, 32'h0);
		ahb(1'b1, `CCO_OFS_CTRL, 32'h0103);
		steps(1, 1'b1);
		steps(1, 1'b0);
		chk(output_a, 1'b1);
		steps(1, 1'b0);
		chk(output_a, 1'b0);
		$display("test pulse direction done");
	endtask
	// verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// hang guard, far beyond the expected few hundred cycles
	initial begin
		#200000;
		n_mismatch++;
		end_of_test();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		t_reset();
		t_soft();
		t_cmp();
		t_pulse();
		t_window();
		t_iso();
		t_hyst();
		t_pdir();
		end_of_test();
	end
endmodule
